//--- rmsr_consts.vh
// Register offsets, reset values, field widths and mode codes for the motion-state registers
`ifndef RMSR_CONSTS_VH
`define RMSR_CONSTS_VH

// Register offsets on the serial register port (register index)
`define RMSR_OFF_ACTUAL_POSITION      7'h18
`define RMSR_OFF_ACTUAL_VELOCITY      7'h19
`define RMSR_OFF_ACTUAL_ACCELERATION  7'h1a
`define RMSR_OFF_START_VELOCITY       7'h1b
`define RMSR_OFF_FIRST_PHASE_ACCEL    7'h1c

// Field widths
`define RMSR_W_POSITION   32
`define RMSR_W_VELOCITY   24
`define RMSR_W_ACCEL_ACT  24
`define RMSR_W_START_VEL  18
`define RMSR_W_PHASE_ACC  18
`define RMSR_W_THRESH_VEL 20

// Reset values
`define RMSR_RST_POSITION  32'h0000_0000
`define RMSR_RST_VELOCITY  24'h00_0000
`define RMSR_RST_ACCEL     24'h00_0000
`define RMSR_RST_START_VEL 18'h0_0000
`define RMSR_RST_PHASE_ACC 18'h0_0000

// Ramp modes
`define RMSR_MODE_POSITIONING 2'h0
`define RMSR_MODE_VEL_POS     2'h1
`define RMSR_MODE_VEL_NEG     2'h2
`define RMSR_MODE_HOLD        2'h3

// Ramp generator update interval in clock cycles
`define RMSR_TICK_CYCLES 16

`endif

//--- rmsr_accel_select.v
// Acceleration value picker for the current ramp phase
`timescale 1ns/1ps
`include "rmsr_consts.vh"

module rmsr_accel_select (
  input  wire        clk,                // System clock
  input  wire        rst_n,              // Synchronous reset, active low
  input  wire [22:0] speedMag,           // Present speed magnitude
  input  wire        rising,             // High while speeding up
  input  wire        posMode,            // High in positioning mode
  input  wire [19:0] firstThresholdVelocity, // Phase-one velocity ceiling
  input  wire [17:0] firstPhaseAccel,    // Phase-one acceleration
  input  wire [17:0] firstPhaseDecel,    // Phase-one deceleration
  input  wire [17:0] maximumAcceleration, // Upper-phase acceleration
  input  wire [17:0] maximumDeceleration, // Upper-phase deceleration
  output reg  [17:0] accelSel            // Chosen step size per tick
);

  // Registered pick; the ramp only updates every few cycles, so the lag is harmless
  always @(posedge clk) begin
    if (!rst_n) begin
      accelSel <= 18'h0_0000;
    end else if (!posMode) begin
      // Velocity modes use only the maximum acceleration
      accelSel <= maximumAcceleration;
    end else if ((firstThresholdVelocity == 20'h0_0000) ||
                 ({1'b0, speedMag} >= {4'h0, firstThresholdVelocity})) begin
      // At or above the threshold, or phase one disabled by a zero threshold
      accelSel <= rising ? maximumAcceleration : maximumDeceleration;
    end else begin
      // Below a nonzero first threshold, whether above or below the start velocity
      accelSel <= rising ? firstPhaseAccel : firstPhaseDecel;
    end
  end

endmodule // rmsr_accel_select

//--- rmsr_motion_regs.v
// Motion-state registers and first-phase ramp parameters with a compact ramp core
`timescale 1ns/1ps
`include "rmsr_consts.vh"

module rmsr_motion_regs #(
  parameter TICK_CYCLES = `RMSR_TICK_CYCLES // Clock cycles per ramp update
) (
  input  wire        clk,                    // System clock, 100 MHz
  input  wire        rst_n,                  // Synchronous reset, active low
  input  wire [6:0]  regAddr,                // Register index from serial port
  input  wire        regWrite,               // One-cycle write strobe
  input  wire [31:0] regWrData,              // Write data
  output reg  [31:0] regRdData,              // Read data for the addressed register
  input  wire [1:0]  rampMode,               // Positioning, velocity or hold
  input  wire [31:0] targetPosition,         // Destination in positioning mode
  input  wire [22:0] maximumVelocity,        // Cruise speed
  input  wire [17:0] stopVelocity,           // Speed at which a stop may snap to zero
  input  wire [19:0] firstThresholdVelocity, // Phase-one velocity ceiling
  input  wire [17:0] maximumAcceleration,    // Upper-phase acceleration
  input  wire [17:0] maximumDeceleration,    // Upper-phase deceleration
  input  wire [17:0] firstPhaseDecel,        // Phase-one deceleration
  output reg         stepPulse,              // One-cycle step strobe
  output reg         stepDir,                // High for increasing position
  output reg         moving                  // High while speed is not zero
);

  // One-hot ramp states
  localparam [2:0] ST_STILL = 3'b001;
  localparam [2:0] ST_MOVE  = 3'b010;
  localparam [2:0] ST_BRAKE = 3'b100;

  // Software-visible state
  reg  [31:0] actualPosition;      // Signed position
  reg  [23:0] actualVelocity;      // Signed velocity
  reg  [23:0] actualAcceleration;  // Applied acceleration magnitude
  reg  [17:0] startVelocity;       // Start speed
  reg  [17:0] firstPhaseAccel;     // Phase-one acceleration

  // Ramp core state
  reg  [2:0]  state;               // One-hot ramp state
  reg  [7:0]  tickCnt;             // Update interval counter
  reg  [22:0] speedMag;            // Speed magnitude
  reg         dirUp;               // Present direction
  reg  [22:0] posFrac;             // Fractional step accumulator
  reg         tick;                // Ramp update strobe

  // Combinational ramp decisions
  reg  [22:0] next_speed;          // Speed after this update
  reg         next_dirUp;          // Direction after this update
  reg  [22:0] tgtSpeed;            // Speed to steer toward
  reg         wantUp;              // Direction the mode asks for
  reg  [23:0] applied;             // Magnitude of speed change

  wire        posMode  = (rampMode == `RMSR_MODE_POSITIONING);
  wire [32:0] distance = {targetPosition[31], targetPosition} -
                         {actualPosition[31], actualPosition};
  wire [31:0] distMag  = distance[32] ? (~distance[31:0] + 32'h0000_0001) : distance[31:0];
  wire        atTarget = (distance == 33'h0_0000_0000);
  wire [27:0] distCap  = (distMag[31:28] != 4'h0) ? 28'hFFF_FFFF : distMag[27:0];
  wire [45:0] speedSq  = speedMag * speedMag;
  // Full-width product; inside a concatenation it would shrink to 28 bits
  wire [45:0] brakeProd = distCap * maximumDeceleration;
  // Speed and acceleration count 2^-23 steps, so the stopping distance in steps is
  // speed^2 / (2^24 * deceleration); dropping 24 bits puts both sides in steps
  wire        mustBrake = ({24'h00_0000, speedSq[45:24]} >= brakeProd);
  wire [17:0] accelSel;            // Acceleration picked for this phase
  wire [23:0] stepSum  = {1'b0, posFrac} + {1'b0, speedMag};
  wire        wrHit;               // Write reaches this block

  // Decoding used by the write path only; the read mux decodes the index itself
  function isOurs;
    input [6:0] a;
    begin
      isOurs = (a >= `RMSR_OFF_ACTUAL_POSITION) && (a <= `RMSR_OFF_FIRST_PHASE_ACCEL);
    end
  endfunction

  assign wrHit = regWrite && isOurs(regAddr);

  // Acceleration for the present phase
  rmsr_accel_select u_accel (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .speedMag               (speedMag),
    .rising                 (speedMag < tgtSpeed),
    .posMode                (posMode),
    .firstThresholdVelocity (firstThresholdVelocity),
    .firstPhaseAccel        (firstPhaseAccel),
    .firstPhaseDecel        (firstPhaseDecel),
    .maximumAcceleration    (maximumAcceleration),
    .maximumDeceleration    (maximumDeceleration),
    .accelSel               (accelSel)
  );

  // Update interval timer
  always @(posedge clk) begin
    if (!rst_n) begin
      tickCnt <= 8'h00;
      tick    <= 1'b0;
    end else if (tickCnt == TICK_CYCLES[7:0] - 8'h01) begin
      tickCnt <= 8'h00;
      tick    <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 8'h01;
      tick    <= 1'b0;
    end
  end

  // Target speed and direction from the mode
  always @* begin
    wantUp   = dirUp;
    tgtSpeed = speedMag;
    case (rampMode)
      `RMSR_MODE_POSITIONING: begin
        wantUp = ~distance[32];
        // A fresh position write lands here and starts motion if off target
        if (atTarget || (maximumVelocity == 23'h00_0000)) begin
          tgtSpeed = 23'h00_0000;
        end else if (mustBrake) begin
          tgtSpeed = 23'h00_0000;
        end else begin
          tgtSpeed = maximumVelocity;
        end
      end
      `RMSR_MODE_VEL_POS: begin
        wantUp   = 1'b1;
        tgtSpeed = maximumVelocity;
      end
      `RMSR_MODE_VEL_NEG: begin
        wantUp   = 1'b0;
        tgtSpeed = maximumVelocity;
      end
      default: begin
        // Hold keeps the present speed
        wantUp   = dirUp;
        tgtSpeed = speedMag;
      end
    endcase
    // Reversal needs a stop first
    if ((speedMag != 23'h00_0000) && (wantUp != dirUp)) begin
      tgtSpeed = 23'h00_0000;
    end
  end

  // Next speed: ramp toward target by the picked acceleration
  always @* begin
    next_speed = speedMag;
    next_dirUp = dirUp;
    applied    = 24'h00_0000;
    if (speedMag == 23'h00_0000) begin
      next_dirUp = wantUp;
    end
    if (posMode && atTarget) begin
      // Arrived: hold still
      next_speed = 23'h00_0000;
    end else if (speedMag < tgtSpeed) begin
      if (posMode && (speedMag == 23'h00_0000) && (startVelocity != 18'h0_0000)) begin
        // Jump straight to start speed, positioning mode only
        next_speed = ({5'h00, startVelocity} < tgtSpeed) ?
                     {5'h00, startVelocity} : tgtSpeed;
      end else if ((tgtSpeed - speedMag) > {5'h00, accelSel}) begin
        next_speed = speedMag + {5'h00, accelSel};
      end else begin
        next_speed = tgtSpeed;
      end
      applied = {6'h00, accelSel};
    end else if (speedMag > tgtSpeed) begin
      if (posMode && (tgtSpeed == 23'h00_0000) &&
          (speedMag <= {5'h00, stopVelocity}) && mustBrake) begin
        // Slow enough to stop outright
        next_speed = 23'h00_0000;
      end else if ((speedMag - tgtSpeed) > {5'h00, accelSel}) begin
        next_speed = speedMag - {5'h00, accelSel};
      end else begin
        next_speed = tgtSpeed;
      end
      applied = {6'h00, accelSel};
    end
  end

  // Ramp state, speed, position and stepping
  always @(posedge clk) begin
    if (!rst_n) begin
      state              <= ST_STILL;
      speedMag           <= 23'h00_0000;
      dirUp              <= 1'b1;
      posFrac            <= 23'h00_0000;
      actualPosition     <= `RMSR_RST_POSITION;
      actualVelocity     <= `RMSR_RST_VELOCITY;
      actualAcceleration <= `RMSR_RST_ACCEL;
      stepPulse          <= 1'b0;
      stepDir            <= 1'b1;
      moving             <= 1'b0;
    end else begin
      stepPulse <= 1'b0;
      if (wrHit && (regAddr == `RMSR_OFF_ACTUAL_POSITION)) begin
        // Software write wins over a step in the same cycle; homing use only
        actualPosition <= regWrData;
      end else if (tick && stepSum[23] && !(posMode && atTarget)) begin
        // Accumulator overflow gives one microstep
        actualPosition <= dirUp ? actualPosition + 32'h0000_0001 :
                                  actualPosition - 32'h0000_0001;
        stepPulse      <= 1'b1;
      end
      if (tick) begin
        posFrac            <= stepSum[22:0];
        speedMag           <= next_speed;
        dirUp              <= next_dirUp;
        stepDir            <= next_dirUp;
        moving             <= (next_speed != 23'h00_0000);
        actualAcceleration <= applied;
        // Signed readback; negative when moving down
        actualVelocity     <= next_dirUp ? {1'b0, next_speed} :
                                           (~{1'b0, next_speed} + 24'h00_0001);
        case (state)
          ST_STILL: state <= (next_speed != 23'h00_0000) ? ST_MOVE : ST_STILL;
          ST_MOVE:  state <= (next_speed == 23'h00_0000) ? ST_STILL :
                             ((next_speed < speedMag) ? ST_BRAKE : ST_MOVE);
          ST_BRAKE: state <= (next_speed == 23'h00_0000) ? ST_STILL :
                             ((next_speed > speedMag) ? ST_MOVE : ST_BRAKE);
          default:  state <= ST_STILL;
        endcase
      end
    end
  end

  // Writable parameter registers; upper bits dropped on write
  always @(posedge clk) begin
    if (!rst_n) begin
      startVelocity   <= `RMSR_RST_START_VEL;
      firstPhaseAccel <= `RMSR_RST_PHASE_ACC;
    end else if (wrHit) begin
      case (regAddr)
        `RMSR_OFF_START_VELOCITY:    startVelocity   <= regWrData[17:0];
        `RMSR_OFF_FIRST_PHASE_ACCEL: firstPhaseAccel <= regWrData[17:0];
        default: ;
      endcase
    end
  end

  // Registered read mux; read-only and unmapped indexes ignore writes
  always @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 32'h0000_0000;
    end else begin
      case (regAddr)
        `RMSR_OFF_ACTUAL_POSITION:     regRdData <= actualPosition;
        `RMSR_OFF_ACTUAL_VELOCITY:     regRdData <= {8'h00, actualVelocity};
        `RMSR_OFF_ACTUAL_ACCELERATION: regRdData <= {8'h00, actualAcceleration};
        `RMSR_OFF_START_VELOCITY:      regRdData <= {14'h0000, startVelocity};
        `RMSR_OFF_FIRST_PHASE_ACCEL:   regRdData <= {14'h0000, firstPhaseAccel};
        default:                       regRdData <= 32'h0000_0000;
      endcase
    end
  end

endmodule // rmsr_motion_regs

//--- rmsr_motion_regs_properties.sv
// Checker for the motion-state register block, bound to its ports
`timescale 1ns/1ps
module rmsr_motion_regs_properties #(
  parameter TICK_CYCLES = 16 // Ramp update interval in clocks
) (
  input wire        clk,
  input wire        rst_n,
  input wire [6:0]  regAddr,
  input wire        regWrite,
  input wire [31:0] regWrData,
  input wire [31:0] regRdData,
  input wire [1:0]  rampMode,
  input wire [31:0] targetPosition,
  input wire [22:0] maximumVelocity,
  input wire [17:0] stopVelocity,
  input wire [19:0] firstThresholdVelocity,
  input wire [17:0] maximumAcceleration,
  input wire [17:0] maximumDeceleration,
  input wire [17:0] firstPhaseDecel,
  input wire        stepPulse,
  input wire        stepDir,
  input wire        moving
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Read data is registered, so every check looks at last cycle's address
  property p_hi18; ($past(regAddr) == 7'h1b || $past(regAddr) == 7'h1c) |-> regRdData[31:18] == 14'h0; endproperty
  a_hi18: assert property (p_hi18) else $error("upper bits of 18-bit register not zero");
  property p_hi24; ($past(regAddr) == 7'h19 || $past(regAddr) == 7'h1a) |-> regRdData[31:24] == 8'h0; endproperty
  a_hi24: assert property (p_hi24) else $error("upper bits of 24-bit readback not zero");
  property p_unmapped; !($past(regAddr) inside {[7'h18:7'h1c]}) |-> regRdData == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index read not zero");
  // A write to 0x18, 0x1b or 0x1c followed by a read of the same index must return the written word, cut to the register width
  property p_pos_wr; (regWrite && regAddr == 7'h18 ##1 !regWrite && regAddr == 7'h18) |=> regRdData == $past(regWrData, 2); endproperty
  a_pos_wr: assert property (p_pos_wr) else $error("position readback differs from write");
  property p_start_wr; (regWrite && regAddr == 7'h1b ##1 !regWrite && regAddr == 7'h1b) |=> regRdData == {14'h0, $past(regWrData[17:0], 2)}; endproperty
  a_start_wr: assert property (p_start_wr) else $error("start velocity readback wrong");
  property p_a1_wr; (regWrite && regAddr == 7'h1c ##1 !regWrite && regAddr == 7'h1c) |=> regRdData == {14'h0, $past(regWrData[17:0], 2)}; endproperty
  a_a1_wr: assert property (p_a1_wr) else $error("first acceleration readback wrong");
  // Velocity and motion flags update on the same tick, so they must agree
  property p_still; ($past(regAddr) == 7'h19 && !$past(moving)) |-> regRdData == 32'h0000_0000; endproperty
  a_still: assert property (p_still) else $error("velocity nonzero at standstill");
  property p_sign; ($past(regAddr) == 7'h19 && $past(moving)) |-> regRdData[23] == !$past(stepDir); endproperty
  a_sign: assert property (p_sign) else $error("velocity sign disagrees with direction");
  property p_step; stepPulse |=> !stepPulse; endproperty
  a_step: assert property (p_step) else $error("step strobe longer than one cycle");
  c_poswr: cover property (regWrite && regAddr == 7'h18 && rampMode == 2'h0);
  c_negstep: cover property (stepPulse && !stepDir);
  c_start: cover property ($rose(moving));
endmodule // rmsr_motion_regs_properties

bind rmsr_motion_regs rmsr_motion_regs_properties #(.TICK_CYCLES(TICK_CYCLES)) u_rmsr_motion_regs_properties (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
  .regRdData(regRdData), .rampMode(rampMode), .targetPosition(targetPosition),
  .maximumVelocity(maximumVelocity), .stopVelocity(stopVelocity),
  .firstThresholdVelocity(firstThresholdVelocity), .maximumAcceleration(maximumAcceleration),
  .maximumDeceleration(maximumDeceleration), .firstPhaseDecel(firstPhaseDecel),
  .stepPulse(stepPulse), .stepDir(stepDir), .moving(moving));

//--- rmsr_motion_regs_tb.sv
// Self-checking testbench for the motion-state register block
`timescale 1ns/1ps
module rmsr_motion_regs_tb;
  logic        clk = 1'b0;            // 100 MHz clock
  logic        rst_n = 1'b0;          // Synchronous reset, active low
  logic [6:0]  regAddr = 7'h00;       // Register index
  logic        regWrite = 1'b0;       // Write strobe
  logic [31:0] regWrData = 32'h0;     // Write data
  wire  [31:0] regRdData;             // Read data
  logic [1:0]  rampMode = 2'h3;       // Start in hold so position writes stay still
  logic [31:0] targetPosition = 32'h0;
  logic [22:0] maximumVelocity = 23'h0;
  logic [17:0] stopVelocity = 18'h0;
  logic [19:0] firstThresholdVelocity = 20'h0;
  logic [17:0] maximumAcceleration = 18'h0;
  logic [17:0] maximumDeceleration = 18'h0;
  logic [17:0] firstPhaseDecel = 18'h0;
  wire         stepPulse;             // Step strobe
  wire         stepDir;               // Direction
  wire         moving;                // Motion flag
  int          mismatches = 0;        // Failed comparisons
  int          n_tests = 0;           // All comparisons
  int          cyc = 0;               // Watchdog cycle count
  int          steps = 0;             // Step strobes seen so far
  int          s0 = 0;                // Step count at the start of a move
  logic [31:0] d;                     // Last read word

  // Short tick keeps the ramp runs brief
  rmsr_motion_regs #(.TICK_CYCLES(2)) u_rmsr_motion_regs (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
    .regRdData(regRdData), .rampMode(rampMode), .targetPosition(targetPosition),
    .maximumVelocity(maximumVelocity), .stopVelocity(stopVelocity),
    .firstThresholdVelocity(firstThresholdVelocity), .maximumAcceleration(maximumAcceleration),
    .maximumDeceleration(maximumDeceleration), .firstPhaseDecel(firstPhaseDecel),
    .stepPulse(stepPulse), .stepDir(stepDir), .moving(moving));

  // Clock generator
  always #5 clk = ~clk;

  // Counts step strobes so a move can be checked step for step
  always @(posedge clk) begin
    if (stepPulse) begin
      steps <= steps + 1;
    end
  end

  // Watchdog: a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe, dropped on the following edge
  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrite <= 1'b1;
    regWrData <= v;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // Index at one edge, word loaded at the next, taken before the third edge updates it
  task automatic rd(input logic [6:0] a);
    @(posedge clk);
    regAddr <= a;
    @(posedge clk);
    @(posedge clk);
    d = regRdData;
  endtask

  // Bounded wait for the motion flag
  task automatic wait_moving(input logic lv);
    int i;
    i = 0;
    while (moving !== lv && i < 20000) begin
      @(posedge clk);
      i++;
    end
    chk({31'h0, moving}, {31'h0, lv});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and unmapped neighbours
    for (int a = 7'h17; a <= 7'h1d; a++) begin
      rd(a[6:0]);
      chk(d, 32'h0000_0000);
    end
    // Readback, truncation and read-only places, in hold mode
    wr(7'h18, 32'h8000_0001);
    rd(7'h18);
    chk(d, 32'h8000_0001);
    wr(7'h1b, 32'hFFFF_FFFF);
    rd(7'h1b);
    chk(d, 32'h0003_FFFF);
    wr(7'h1c, 32'hFFFF_FFFF);
    rd(7'h1c);
    chk(d, 32'h0003_FFFF);
    wr(7'h19, 32'hFFFF_FFFF);
    wr(7'h1a, 32'hFFFF_FFFF);
    rd(7'h19);
    chk(d, 32'h0000_0000);
    rd(7'h1a);
    chk(d, 32'h0000_0000);
    // Park on target, then switch to positioning: no motion expected
    targetPosition <= 32'h0000_0064;
    maximumVelocity <= 23'h40_0000;
    maximumAcceleration <= 18'h1_0000;
    maximumDeceleration <= 18'h1_0000;
    // Phase-one deceleration differs from acceleration so the readback tells them apart
    firstPhaseDecel <= 18'h0_4000;
    stopVelocity <= 18'h0_1000;
    firstThresholdVelocity <= 20'hF_FFFF;
    wr(7'h1b, 32'h0000_0000);
    wr(7'h1c, 32'h0000_8000);
    wr(7'h18, 32'h0000_0064);
    rampMode <= 2'h0;
    repeat (20) @(posedge clk);
    chk({31'h0, moving}, 32'h0);
    // Position write away from target starts an upward move in phase one
    s0 = steps;
    wr(7'h18, 32'h0000_0000);
    wait_moving(1'b1);
    rd(7'h1a);
    chk(d, 32'h0000_8000);
    rd(7'h19);
    chk({31'h0, d[23]}, 32'h0);
    wait_moving(1'b0);
    rd(7'h18);
    chk(d, 32'h0000_0064);
    chk(steps - s0, 32'h0000_0064);
    // Zero threshold: downward move uses the maximum acceleration and deceleration only
    firstThresholdVelocity <= 20'h0_0000;
    s0 = steps;
    wr(7'h18, 32'h0000_00C8);
    wait_moving(1'b1);
    chk({31'h0, stepDir}, 32'h0);
    rd(7'h1a);
    chk(d, 32'h0001_0000);
    rd(7'h19);
    chk({31'h0, d[23]}, 32'h1);
    wait_moving(1'b0);
    rd(7'h18);
    chk(d, 32'h0000_0064);
    chk(steps - s0, 32'h0000_0064);
    // Velocity mode ignores a large start velocity
    maximumAcceleration <= 18'h0_0100;
    wr(7'h1b, 32'h0003_0000);
    rampMode <= 2'h1;
    wait_moving(1'b1);
    rd(7'h19);
    chk({31'h0, d[23:0] < 24'h03_0000}, 32'h1);
    // Reset in mid-run clears the position while the ramp is running
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(7'h18);
    chk(d, 32'h0000_0000);
    finish_test();
  end
endmodule // rmsr_motion_regs_tb
